// [verilog/link_regs_pkg.sv]
// register map, field positions and reset values of the link control register bank
package link_regs_pkg;
  localparam int ADDR_W = 7;
  localparam logic [6:0] OFS_PART_IDENTITY = 7'h00;
  localparam logic [6:0] OFS_SPARE_A = 7'h04;
  localparam logic [6:0] OFS_LINK_CONTROL = 7'h08;
  localparam logic [6:0] OFS_ASYNC_RETRY = 7'h4C;
  localparam logic [6:0] OFS_CTL_TX_FIRST = 7'h50;
  localparam logic [6:0] OFS_CTL_TX_LAST = 7'h54;
  localparam logic [6:0] OFS_SPARE_B = 7'h58;
  localparam logic [6:0] OFS_CTL_RX_PORT = 7'h5C;
  localparam logic [6:0] OFS_PROTO_CTRL = 7'h60;
  localparam logic [6:0] OFS_PROTO_STAT = 7'h64;
  localparam logic [6:0] OFS_PARAM_CTRL = 7'h68;
  localparam logic [6:0] OFS_PARAM_DATA = 7'h6C;
  localparam logic [6:0] OFS_CMD_FIRST = 7'h70;
  localparam logic [6:0] OFS_CMD_LAST = 7'h74;
  localparam logic [6:0] OFS_BULK_PORT = 7'h78;
  localparam logic [6:0] OFS_SPARE_C = 7'h7C;
  // bit numbers count from the msb: bit 00 is data[31]
  localparam int BIT_SOFT_RESET = 31;
  localparam int BIT_PAGE_SELECT = 28;
  localparam int BIT_BUSY_POLICY = 27;
  localparam int BIT_TX_ENABLE = 26;
  localparam int BIT_RX_ENABLE = 25;
  localparam logic [31:0] CONTROL_WMASK = 32'h1E000000;
  localparam logic [31:0] CONTROL_RESET = 32'h06000000;
  localparam logic [31:0] SCRATCH_RESET = 32'h00000000;
  localparam int SCRATCH_ROWS = 11;
  // writable lane is the most significant byte only
  localparam logic [3:0] WRITE_LANES = 4'h8;
  localparam logic [31:0] PART_ID_DEFAULT = 32'h0A5C0001; // arbitrary value
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int SOFT_RESET_CYCLES = 4;
  localparam logic [2:0] SOFT_RESET_LAST = 3'h3;
endpackage

// [verilog/link_control_register_bank.sv]
// axi4-lite register bank with control bits for a serial-bus link controller
//
// Contract
// - bytes go out msb first on the bus
// - quadlets go out most significant byte first
// - software writes land in byte lane 00:07
// - fields obey read, write and update tags
// - version register returns fixed id, ignores writes
// - control bit 00 triggers a device reset
// - page bit picks 256-byte half of ram
// - busy policy bit forces busy acknowledges
// - tx enable gates arbitration and sending, resets set; here only serial loads are gated, a loaded byte still shifts out
// - rx enable gates receiving, bus reset leaves it
// - other control bits power up cleared; rx enable powers up set here
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/10ps
module link_control_register_bank #(
  parameter logic [31:0] PART_ID = link_regs_pkg::PART_ID_DEFAULT
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [6:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [6:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic bus_reset,
  input wire logic [7:0] tx_byte,
  input wire logic tx_byte_load,
  output logic tx_serial_bit,
  input wire logic [31:0] tx_quadlet,
  output logic [7:0] tx_quadlet_byte [4],
  output logic device_reset,
  output logic data_mem_page_select,
  output logic busy_ack_policy,
  output logic transmitter_enable,
  output logic receiver_enable
);
  logic rst_meta;
  logic rst_sync_n;
  logic aw_held;
  logic w_held;
  logic [6:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] link_control;
  logic [31:0] scratch [link_regs_pkg::SCRATCH_ROWS];
  logic [2:0] soft_count;
  logic soft_active;
  logic [7:0] tx_shift;
  logic do_write;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  // decode of a register slot; reserved ones answer okay and read zero
  function automatic logic is_scratch(input logic [6:0] a);
    return (a >= link_regs_pkg::OFS_ASYNC_RETRY) && (a <= link_regs_pkg::OFS_BULK_PORT)
      && (a != link_regs_pkg::OFS_SPARE_B);
  endfunction

  // the spare slot between the fifo rows is squeezed out of the index
  function automatic logic [3:0] scratch_index(input logic [6:0] a);
    logic [6:0] d;
    d = a - link_regs_pkg::OFS_ASYNC_RETRY;
    return (d[6:2] > 5'd3) ? 4'(d[6:2] - 5'd1) : 4'(d[6:2]);
  endfunction

  // rows outside this bank, the interrupt block among them, answer slave error
  function automatic logic is_mapped(input logic [6:0] a);
    return (a <= link_regs_pkg::OFS_LINK_CONTROL) || (a >= link_regs_pkg::OFS_ASYNC_RETRY);
  endfunction

  // only reset_n feeds the bank; its release is synchronised through two flops
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // both write channels refuse a second item until the write response is taken; the read channel until the read data is taken
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 7'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= link_regs_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_held)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(aw_addr) ? link_regs_pkg::RESP_OKAY
          : link_regs_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end

  // control register: only the writable bits of the msb lane change
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      link_control <= link_regs_pkg::CONTROL_RESET;
    else if (do_write && aw_addr == link_regs_pkg::OFS_LINK_CONTROL
      && (w_strb & link_regs_pkg::WRITE_LANES) != 4'h0)
      link_control <= (link_control & ~link_regs_pkg::CONTROL_WMASK)
        | (w_data & link_regs_pkg::CONTROL_WMASK);
  end

  // bus_reset is deliberately not a term here
  // enables survive bus reset
  assign transmitter_enable = link_control[link_regs_pkg::BIT_TX_ENABLE];
  assign receiver_enable = link_control[link_regs_pkg::BIT_RX_ENABLE];
  assign data_mem_page_select = link_control[link_regs_pkg::BIT_PAGE_SELECT];
  assign busy_ack_policy = link_control[link_regs_pkg::BIT_BUSY_POLICY];

  // soft reset: a pulse of fixed length; the bit reads as set while it runs
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      soft_active <= 1'b0;
      soft_count <= 3'h0;
    end
    else if (do_write && aw_addr == link_regs_pkg::OFS_LINK_CONTROL
      && w_strb[3] && w_data[link_regs_pkg::BIT_SOFT_RESET])
    begin
      soft_active <= 1'b1;
      soft_count <= 3'h0;
    end
    else if (soft_active)
    begin
      soft_count <= soft_count + 3'h1;
      if (soft_count == link_regs_pkg::SOFT_RESET_LAST)
        soft_active <= 1'b0;
    end
  end
  assign device_reset = soft_active;

  // the other register rows are plain storage in the msb lane
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      for (int i = 0; i < link_regs_pkg::SCRATCH_ROWS; i++)
        scratch[i] <= link_regs_pkg::SCRATCH_RESET;
    end
    else if (do_write && is_scratch(aw_addr) && w_strb[3])
      scratch[scratch_index(aw_addr)] <= {w_data[31:24], 24'h000000};
  end

  always_comb
  begin
    next_rdata = 32'h00000000;
    next_rresp = link_regs_pkg::RESP_OKAY;
    if (s_axi_araddr == link_regs_pkg::OFS_PART_IDENTITY)
      next_rdata = PART_ID;
    else if (s_axi_araddr == link_regs_pkg::OFS_LINK_CONTROL)
    begin
      next_rdata = link_control;
      next_rdata[link_regs_pkg::BIT_SOFT_RESET] = soft_active;
    end
    else if (is_scratch(s_axi_araddr))
      next_rdata = scratch[scratch_index(s_axi_araddr)];
    else if (!is_mapped(s_axi_araddr))
      next_rresp = link_regs_pkg::RESP_SLVERR;
  end

  // read data is captured on acceptance, so it stands until rready
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= link_regs_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // serialiser: loads are ignored while transmit disabled, but the shifter keeps shifting out what it holds
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      tx_shift <= 8'h00;
    else if (tx_byte_load && transmitter_enable)
      tx_shift <= tx_byte;
    else
      tx_shift <= {tx_shift[6:0], 1'b0};
  end
  assign tx_serial_bit = tx_shift[7];

  // registered so all four lanes leave in one cycle
  // byte order on the wire
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      for (int i = 0; i < 4; i++)
        tx_quadlet_byte[i] <= 8'h00;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
        tx_quadlet_byte[i] <= tx_quadlet[31 - 8 * i -: 8];
    end
  end

  // checks on the register bus answers, the control bits and the serial and quadlet outputs
  chk_part_id_fixed: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (s_axi_arvalid && !s_axi_rvalid && s_axi_araddr == link_regs_pkg::OFS_PART_IDENTITY)
    |=> s_axi_rdata == PART_ID)
    else $error("identity read wrong");
  chk_ctl_reset_value: assert property (@(posedge mclk)
    $rose(rst_sync_n) |-> link_control == link_regs_pkg::CONTROL_RESET)
    else $error("control reset value wrong");
  // a load while transmit is off must not reach the shifter
  chk_tx_gate: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (tx_byte_load && !transmitter_enable) |=> tx_shift == {$past(tx_shift[6:0]), 1'b0})
    else $error("load taken while transmit off");
  chk_rx_bus_reset: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (bus_reset && !do_write) |=> $stable(receiver_enable))
    else $error("rx enable changed on bus reset");
  chk_ctl_lane_write: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (do_write && aw_addr == link_regs_pkg::OFS_LINK_CONTROL && w_strb[3])
    |=> busy_ack_policy == $past(w_data[link_regs_pkg::BIT_BUSY_POLICY]))
    else $error("control lane write lost");
  chk_reserved_bits: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (link_control & ~link_regs_pkg::CONTROL_WMASK) == 32'h00000000)
    else $error("reserved control bit set");
  chk_soft_reset_len: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    $rose(device_reset) |-> device_reset [*4] ##1 !device_reset)
    else $error("soft reset pulse length");
  chk_msb_first_out: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (tx_byte_load && transmitter_enable) |=> tx_serial_bit == $past(tx_byte[7]) ##1
      tx_serial_bit == $past(tx_byte[6], 2))
    else $error("bit order wrong");
  chk_quad_order: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    rst_sync_n |=> tx_quadlet_byte[0] == $past(tx_quadlet[31:24])
      && tx_quadlet_byte[1] == $past(tx_quadlet[23:16])
      && tx_quadlet_byte[2] == $past(tx_quadlet[15:8])
      && tx_quadlet_byte[3] == $past(tx_quadlet[7:0]))
    else $error("byte order wrong");
  chk_page_sel: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (do_write && aw_addr == link_regs_pkg::OFS_LINK_CONTROL && w_strb[3])
    |=> data_mem_page_select == $past(w_data[link_regs_pkg::BIT_PAGE_SELECT]))
    else $error("page select not written");
  chk_read_latency: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("read answer late");
  chk_write_answer: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    do_write |=> s_axi_bvalid)
    else $error("write answer missing");
  // a slot outside the bank must not look like a stored register
  chk_unmapped_werr: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (do_write && !is_mapped(aw_addr)) |=> s_axi_bresp == link_regs_pkg::RESP_SLVERR)
    else $error("unmapped write answered okay");
  chk_unmapped_rerr: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (s_axi_arvalid && !s_axi_rvalid && !is_mapped(s_axi_araddr))
    |=> s_axi_rresp == link_regs_pkg::RESP_SLVERR)
    else $error("unmapped read answered okay");
  chk_spare_read_zero: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (s_axi_arvalid && !s_axi_rvalid && (s_axi_araddr == link_regs_pkg::OFS_SPARE_A
      || s_axi_araddr == link_regs_pkg::OFS_SPARE_B
      || s_axi_araddr == link_regs_pkg::OFS_SPARE_C))
    |=> s_axi_rdata == 32'h00000000 && s_axi_rresp == link_regs_pkg::RESP_OKAY)
    else $error("spare slot not zero");
  chk_scratch_lane: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (s_axi_arvalid && !s_axi_rvalid && is_scratch(s_axi_araddr))
    |=> s_axi_rdata[23:0] == 24'h000000)
    else $error("lower lanes stored");
  chk_strobe_ignored: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (do_write && aw_addr == link_regs_pkg::OFS_LINK_CONTROL && !w_strb[3])
    |=> $stable(link_control))
    else $error("write without msb lane landed");
  // the soft reset bit is not stored; it shows the pulse while it runs
  chk_soft_bit_read: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (s_axi_arvalid && !s_axi_rvalid && s_axi_araddr == link_regs_pkg::OFS_LINK_CONTROL)
    |=> s_axi_rdata[link_regs_pkg::BIT_SOFT_RESET] == $past(soft_active))
    else $error("soft reset bit reads wrong");
  chk_ctl_readback: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (s_axi_arvalid && !s_axi_rvalid && s_axi_araddr == link_regs_pkg::OFS_LINK_CONTROL)
    |=> (s_axi_rdata & link_regs_pkg::CONTROL_WMASK)
      == ($past(link_control) & link_regs_pkg::CONTROL_WMASK))
    else $error("control readback wrong");
  // control fields and the link side
  chk_tx_enable_write: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (do_write && aw_addr == link_regs_pkg::OFS_LINK_CONTROL && w_strb[3])
    |=> transmitter_enable == $past(w_data[link_regs_pkg::BIT_TX_ENABLE]))
    else $error("tx enable not written");
  chk_rx_enable_write: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (do_write && aw_addr == link_regs_pkg::OFS_LINK_CONTROL && w_strb[3])
    |=> receiver_enable == $past(w_data[link_regs_pkg::BIT_RX_ENABLE]))
    else $error("rx enable not written");
  chk_soft_cause: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    $rose(device_reset) |-> $past(do_write) && $past(w_data[link_regs_pkg::BIT_SOFT_RESET]))
    else $error("device reset without request");
  chk_msb_last_bit: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (tx_byte_load && transmitter_enable) ##1 !tx_byte_load [*7]
    |=> tx_serial_bit == $past(tx_byte[0], 8))
    else $error("last bit wrong");
  // main scenarios
  cov_write_ctl: cover property (@(posedge mclk) do_write
    && aw_addr == link_regs_pkg::OFS_LINK_CONTROL);
  cov_soft_reset: cover property (@(posedge mclk) $rose(device_reset));
  cov_id_read: cover property (@(posedge mclk) s_axi_rvalid && s_axi_rdata == PART_ID);
  cov_unmapped: cover property (@(posedge mclk) s_axi_bvalid
    && s_axi_bresp == link_regs_pkg::RESP_SLVERR);
  cov_tx_load: cover property (@(posedge mclk) tx_byte_load && transmitter_enable);
endmodule

// [tb/link_control_register_bank_test.sv]
// self-checking bench for the link control register bank
`timescale 1ns/10ps
module link_control_register_bank_test;
  typedef struct {logic [6:0] a; logic [31:0] d; logic [3:0] s; logic [31:0] q; logic [1:0] r;} row_t;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [6:0] s_axi_awaddr = 7'h00, s_axi_araddr = 7'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h00000000, tx_quadlet = 32'h00000000, rd;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic bus_reset = 1'b0, tx_byte_load = 1'b0, tx_serial_bit, device_reset;
  logic [7:0] tx_byte = 8'h00, sb;
  logic [7:0] tx_quadlet_byte [4];
  logic data_mem_page_select, busy_ack_policy, transmitter_enable, receiver_enable;
  int failures = 0, n_compared = 0, dr_cnt = 0;
  // ctrl bit 00 of each field sits at data[31]; only lane 3 is stored
  row_t rows [10] = '{
    '{7'h08, 32'h1E000000, 4'hF, 32'h1E000000, 2'h0},
    '{7'h08, 32'hFFFFFFFF, 4'h7, 32'h1E000000, 2'h0},
    '{7'h08, 32'h61FFFFFF, 4'h8, 32'h00000000, 2'h0},
    '{7'h4C, 32'hA5123456, 4'hF, 32'hA5000000, 2'h0},
    '{7'h78, 32'h5A00FFFF, 4'h8, 32'h5A000000, 2'h0},
    '{7'h00, 32'hFFFFFFFF, 4'hF, link_regs_pkg::PART_ID_DEFAULT, 2'h0},
    '{7'h04, 32'hFFFFFFFF, 4'hF, 32'h00000000, 2'h0},
    '{7'h58, 32'hFFFFFFFF, 4'hF, 32'h00000000, 2'h0},
    '{7'h7C, 32'hFFFFFFFF, 4'hF, 32'h00000000, 2'h0},
    '{7'h0C, 32'hFFFFFFFF, 4'hF, 32'h00000000, 2'h2}};
  always #50 mclk = ~mclk;
  always @(posedge mclk) if (device_reset === 1'b1) dr_cnt <= dr_cnt + 1;
  link_control_register_bank dut (.mclk(mclk), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(rd),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .bus_reset(bus_reset), .tx_byte(tx_byte), .tx_byte_load(tx_byte_load),
    .tx_serial_bit(tx_serial_bit), .tx_quadlet(tx_quadlet), .tx_quadlet_byte(tx_quadlet_byte),
    .device_reset(device_reset), .data_mem_page_select(data_mem_page_select),
    .busy_ack_policy(busy_ack_policy), .transmitter_enable(transmitter_enable),
    .receiver_enable(receiver_enable));
  task automatic summarize();
    if (failures == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %0t %s seen %h want %h", $time, m, seen, exp);
    end
  endtask
  task automatic give_up();
    failures++;
    $display("BAD %0t no handshake", $time);
    summarize();
  endtask
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [6:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge mclk);
      n++;
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
      if (n > 50) give_up();
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdx(input logic [6:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge mclk);
      n++;
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
      if (n > 50) give_up();
    end
    sb = rd[31:24];
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic reset_run();
    reset_n <= 1'b0;
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask
  task automatic serial_byte(input logic [7:0] b, input logic [7:0] exp);
    logic [7:0] got;
    int n;
    got = 8'h00;
    tx_byte <= b;
    tx_byte_load <= 1'b1;
    @(posedge mclk);
    tx_byte_load <= 1'b0;
    // first bit sent is a one here, so it marks the frame start
    for (n = 0; n < 4 && tx_serial_bit !== 1'b1; n++) @(posedge mclk);
    for (n = 0; n < 8; n++)
    begin
      got = {got[6:0], tx_serial_bit};
      @(posedge mclk);
    end
    chk(got, exp, "serial byte");
  endtask
  initial
  begin
    reset_run();
    rdx(link_regs_pkg::OFS_LINK_CONTROL);
    chk(rd, link_regs_pkg::CONTROL_RESET, "control reset");
    chk({device_reset, data_mem_page_select, busy_ack_policy}, 0, "reset outs");
    for (int i = 0; i < 10; i++)
    begin
      wr(rows[i].a, rows[i].d, rows[i].s);
      chk(rsp, rows[i].r, "bresp");
      rdx(rows[i].a);
      chk(rsp, rows[i].r, "rresp");
      if (rows[i].r == link_regs_pkg::RESP_OKAY) chk(rd, rows[i].q, "rdata");
      if (i == 0) chk({data_mem_page_select, busy_ack_policy}, 2'h3, "page busy");
    end
    chk({transmitter_enable, receiver_enable}, 2'h0, "enables off");
    // gated transmitter must stay silent
    serial_byte(8'hB4, 8'h00);
    // cleared before the pulse starts, so the counter has one writer per edge
    dr_cnt <= 0;
    bus_reset <= 1'b1;
    wr(link_regs_pkg::OFS_LINK_CONTROL, 32'h86000000, 4'h8);
    rdx(link_regs_pkg::OFS_LINK_CONTROL);
    chk(rd, 32'h86000000, "soft bit while pulse runs");
    repeat (10) @(posedge mclk);
    chk(dr_cnt, link_regs_pkg::SOFT_RESET_CYCLES, "soft reset len");
    chk({transmitter_enable, receiver_enable}, 2'h3, "bus reset keeps");
    bus_reset <= 1'b0;
    serial_byte(8'hB4, 8'hB4);
    tx_quadlet <= 32'h11223344;
    repeat (2) @(posedge mclk);
    chk({tx_quadlet_byte[0], tx_quadlet_byte[1]}, 16'h1122, "quadlet high");
    chk({tx_quadlet_byte[2], tx_quadlet_byte[3]}, 16'h3344, "quadlet low");
    wr(link_regs_pkg::OFS_LINK_CONTROL, 32'h18000000, 4'h8);
    reset_run();
    rdx(link_regs_pkg::OFS_LINK_CONTROL);
    chk(rd, link_regs_pkg::CONTROL_RESET, "second reset");
    summarize();
  end
endmodule
